// File: verilog/ehsvc_pkg.sv
// package: offsets, field layout, reset values for the error header and id register bank
package ehsvc_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] OFF_LOG_WORD0 = 12'h11c;
  localparam logic [11:0] OFF_LOG_WORD1 = 12'h120;
  localparam logic [11:0] OFF_LOG_WORD2 = 12'h124;
  localparam logic [11:0] OFF_LOG_WORD3 = 12'h128;
  localparam logic [11:0] OFF_SERIAL_CAP_HEADER = 12'h180;
  localparam logic [11:0] OFF_UNIQUE_ID_LOW = 12'h184;
  localparam logic [11:0] OFF_UNIQUE_ID_HIGH = 12'h188;
  localparam logic [11:0] OFF_VCHAN_CAP_HEADER = 12'h200;
  localparam logic [11:0] OFF_WRITE_LOCK = 12'h300;
  localparam logic [11:0] OFF_ERROR_POINTER = 12'h304;

  // capability header fields
  localparam int unsigned TYPE_CODE_LSB = 0;
  localparam int unsigned TYPE_CODE_W = 16;
  localparam int unsigned VERSION_LSB = 16;
  localparam int unsigned VERSION_W = 4;
  localparam int unsigned NEXT_OFFSET_LSB = 20;
  localparam int unsigned NEXT_OFFSET_W = 12;
  localparam logic [15:0] SERIAL_TYPE_CODE = 16'h0003;
  localparam logic [15:0] VCHAN_TYPE_CODE = 16'h0002;
  localparam logic [3:0] STRUCTURE_VERSION = 4'h1;
  localparam logic [11:0] NEXT_OFFSET_END = 12'h000;

  // reset values
  localparam logic [31:0] LOG_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] UNIQUE_ID_RESET = 32'h0000_0000;
  localparam logic [11:0] SERIAL_NEXT_RESET = 12'h200;
  localparam logic [11:0] VCHAN_NEXT_RESET = 12'h000;
  localparam logic WRITE_LOCK_RESET = 1'b0;
  localparam logic [4:0] POINTER_RESET = 5'h00;

  // fields of the pointer status and write lock registers
  localparam int unsigned POINTER_LSB = 0;
  localparam int unsigned POINTER_W = 5;
  localparam int unsigned POINTER_VALID_BIT = 8;
  localparam int unsigned WRITE_LOCK_BIT = 0;

  // header log geometry
  localparam int unsigned LOG_WORDS = 4;
  localparam int unsigned WORD_W = 32;
endpackage

// File: verilog/ehsvc_regs.sv
// apb register bank: first-error header log, serial id structure, vc structure header
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE_01] word at 0x11c shows header doubleword one of first uncorrectable error
// [RULE_02] word at 0x120 shows header doubleword two of that packet
// [RULE_03] word at 0x124 shows header doubleword three of that packet
// [RULE_04] word at 0x128 shows header doubleword four of that packet
// [RULE_05] all four log words load together, only on a first error, never while pointed bit set; unlocked apb writes also load single words
// [RULE_06] five-bit pointer names the status bit that caused the logged error
// [RULE_07] serial header bits 15:0 read constant 0x3
// [RULE_08] both structure headers read version 0x1 in bits 19:16
// [RULE_09] header bits 31:20 hold next structure offset, zero ends the chain
// [RULE_10] word at 0x184 holds low half of the unique id, resets zero, lockable
// [RULE_11] word at 0x188 holds high half of the unique id, resets zero, lockable
// [RULE_12] vc header bits 15:0 read constant 0x2
module ehsvc_regs (
  input wire logic pclk, // bus clock, 50 mhz
  input wire logic presetn, // power-on reset, clears sticky state too
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb write byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic soft_reset, // port reset, keeps sticky log words
  input wire logic capture_valid, // one-cycle uncorrectable error report
  input wire logic [4:0] capture_bit, // status bit of the reported error
  input wire logic [127:0] capture_header, // packet header, word0 in low bits
  input wire logic [31:0] error_status, // uncorrectable error status bits
  output logic [4:0] first_error_pointer, // pointer to logged status bit
  output logic [63:0] unique_id // current 64-bit unique id
);
  localparam int unsigned W = ehsvc_pkg::WORD_W;

  // byte-strobe merge for writable words
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] log_reg [ehsvc_pkg::LOG_WORDS];
  logic [31:0] log_next [ehsvc_pkg::LOG_WORDS];
  logic [31:0] uid_low_reg, uid_low_next, uid_high_reg, uid_high_next;
  logic [11:0] serial_next_reg, serial_next_next, vchan_next_reg, vchan_next_next;
  logic lock_reg, lock_next;
  logic [4:0] ptr_reg, ptr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;

  // address decode
  wire hit_log0 = (paddr == ehsvc_pkg::OFF_LOG_WORD0);
  wire hit_log1 = (paddr == ehsvc_pkg::OFF_LOG_WORD1);
  wire hit_log2 = (paddr == ehsvc_pkg::OFF_LOG_WORD2);
  wire hit_log3 = (paddr == ehsvc_pkg::OFF_LOG_WORD3);
  wire hit_scap = (paddr == ehsvc_pkg::OFF_SERIAL_CAP_HEADER);
  wire hit_uidl = (paddr == ehsvc_pkg::OFF_UNIQUE_ID_LOW);
  wire hit_uidh = (paddr == ehsvc_pkg::OFF_UNIQUE_ID_HIGH);
  wire hit_vcap = (paddr == ehsvc_pkg::OFF_VCHAN_CAP_HEADER);
  wire hit_lock = (paddr == ehsvc_pkg::OFF_WRITE_LOCK);
  wire hit_ptr = (paddr == ehsvc_pkg::OFF_ERROR_POINTER);
  wire [3:0] hit_log = {hit_log3, hit_log2, hit_log1, hit_log0};
  wire hit_any = (|hit_log) | hit_scap | hit_uidl | hit_uidh | hit_vcap | hit_lock | hit_ptr;

  // bus phases; no wait state, read data and ready come from flops loaded in setup
  wire setup_phase = psel & ~penable;
  wire wr_fire = psel & penable & pready_reg & pwrite & hit_any;
  wire wr_open = wr_fire & ~lock_reg; // locked words ignore writes

  // first-error capture: pointer valid while its status bit stays set
  wire ptr_valid = error_status[ptr_reg]; // RULE_06
  wire cap_take = capture_valid & ~ptr_valid; // RULE_05

  // header log words: capture beats a software write in the same cycle
  genvar g;
  generate
    for (g = 0; g < ehsvc_pkg::LOG_WORDS; g++) begin : g_log
      assign log_next[g] = cap_take ? capture_header[W*g +: W] : // RULE_05
                           (wr_open & hit_log[g]) ? merge_bytes(log_reg[g], pwdata, pstrb) :
                           log_reg[g];
      // sticky: only the power-on reset clears it, soft_reset does not
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          log_reg[g] <= ehsvc_pkg::LOG_WORD_RESET;
        end else begin
          log_reg[g] <= log_next[g]; // RULE_01 RULE_02 RULE_03 RULE_04
        end
      end
    end
  endgenerate

  // pointer is sticky with the log, loaded in the same cycle
  assign ptr_next = cap_take ? capture_bit : ptr_reg; // RULE_06

  // non-sticky lockable words
  assign uid_low_next = soft_reset ? ehsvc_pkg::UNIQUE_ID_RESET :
                        (wr_open & hit_uidl) ? merge_bytes(uid_low_reg, pwdata, pstrb) :
                        uid_low_reg; // RULE_10
  assign uid_high_next = soft_reset ? ehsvc_pkg::UNIQUE_ID_RESET :
                         (wr_open & hit_uidh) ? merge_bytes(uid_high_reg, pwdata, pstrb) :
                         uid_high_reg; // RULE_11
  assign serial_next_next = soft_reset ? ehsvc_pkg::SERIAL_NEXT_RESET :
                            (wr_open & hit_scap & pstrb[3] & pstrb[2]) ?
                            pwdata[ehsvc_pkg::NEXT_OFFSET_LSB +: ehsvc_pkg::NEXT_OFFSET_W] :
                            serial_next_reg; // RULE_09
  assign vchan_next_next = soft_reset ? ehsvc_pkg::VCHAN_NEXT_RESET :
                           (wr_open & hit_vcap & pstrb[3] & pstrb[2]) ?
                           pwdata[ehsvc_pkg::NEXT_OFFSET_LSB +: ehsvc_pkg::NEXT_OFFSET_W] :
                           vchan_next_reg; // RULE_09
  // the lock itself is never locked, else software could not reopen it
  assign lock_next = soft_reset ? ehsvc_pkg::WRITE_LOCK_RESET :
                     (wr_fire & hit_lock & pstrb[0]) ? pwdata[ehsvc_pkg::WRITE_LOCK_BIT] :
                     lock_reg;

  // read data assembly
  wire [31:0] rd_scap = {serial_next_reg, ehsvc_pkg::STRUCTURE_VERSION,
                         ehsvc_pkg::SERIAL_TYPE_CODE}; // RULE_07 RULE_08 RULE_09
  wire [31:0] rd_vcap = {vchan_next_reg, ehsvc_pkg::STRUCTURE_VERSION,
                         ehsvc_pkg::VCHAN_TYPE_CODE}; // RULE_12 RULE_08 RULE_09
  wire [31:0] rd_ptr = {23'h000000, ptr_valid, 3'h0, ptr_reg};
  wire [31:0] rd_lock = {31'h00000000, lock_reg};
  wire [31:0] rd_mux = ({32{hit_log0}} & log_reg[0]) | ({32{hit_log1}} & log_reg[1]) |
                       ({32{hit_log2}} & log_reg[2]) | ({32{hit_log3}} & log_reg[3]) |
                       ({32{hit_scap}} & rd_scap) | ({32{hit_vcap}} & rd_vcap) |
                       ({32{hit_uidl}} & uid_low_reg) | ({32{hit_uidh}} & uid_high_reg) |
                       ({32{hit_ptr}} & rd_ptr) | ({32{hit_lock}} & rd_lock);

  // response: sampled in setup, shown through the access phase
  assign pready_next = setup_phase;
  assign pslverr_next = setup_phase & ~hit_any;
  assign prdata_next = (setup_phase & ~pwrite) ? rd_mux : 32'h0000_0000;

  // bus response flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // control and id flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uid_low_reg <= ehsvc_pkg::UNIQUE_ID_RESET;
      uid_high_reg <= ehsvc_pkg::UNIQUE_ID_RESET;
      serial_next_reg <= ehsvc_pkg::SERIAL_NEXT_RESET;
      vchan_next_reg <= ehsvc_pkg::VCHAN_NEXT_RESET;
      lock_reg <= ehsvc_pkg::WRITE_LOCK_RESET;
      ptr_reg <= ehsvc_pkg::POINTER_RESET;
    end else begin
      uid_low_reg <= uid_low_next;
      uid_high_reg <= uid_high_next;
      serial_next_reg <= serial_next_next;
      vchan_next_reg <= vchan_next_next;
      lock_reg <= lock_next;
      ptr_reg <= ptr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign first_error_pointer = ptr_reg;
  assign unique_id = {uid_high_reg, uid_low_reg};

  // checks on the bank's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire rd_access = psel & penable & pready_reg & ~pwrite;

  AST_LOG_WORD0_CAPTURE: assert property ( // RULE_01
    cap_take |=> log_reg[0] == $past(capture_header[31:0]))
    else $error("log word0 did not take header doubleword one");
  AST_LOG_WORD1_CAPTURE: assert property ( // RULE_02
    cap_take |=> log_reg[1] == $past(capture_header[63:32]))
    else $error("log word1 did not take header doubleword two");
  AST_LOG_WORD2_CAPTURE: assert property ( // RULE_03
    cap_take |=> log_reg[2] == $past(capture_header[95:64]))
    else $error("log word2 did not take header doubleword three");
  AST_LOG_WORD3_READ: assert property ( // RULE_04
    setup_phase & ~pwrite & hit_log3 & ~cap_take ##1 rd_access |-> prdata == log_reg[3])
    else $error("log word3 read back wrong");
  AST_LOG_HOLD_WHILE_SET: assert property ( // RULE_05
    (ptr_valid & ~(wr_open & (|hit_log))) |=> $stable(log_reg[0]) && $stable(log_reg[1])
      && $stable(log_reg[2]) && $stable(log_reg[3]) && $stable(ptr_reg))
    else $error("header log changed while first error still pending");
  AST_POINTER_LOAD: assert property ( // RULE_06
    capture_valid & ~error_status[ptr_reg] |=> ptr_reg == $past(capture_bit))
    else $error("first error pointer not loaded");
  AST_SERIAL_HEADER_ID: assert property ( // RULE_07
    setup_phase & ~pwrite & hit_scap |=> prdata[19:0] == 20'h10003 && pready)
    else $error("serial header type or version wrong");
  AST_VCHAN_HEADER_ID: assert property ( // RULE_12
    setup_phase & ~pwrite & hit_vcap |=> prdata[15:0] == 16'h0002 && prdata[19:16] == 4'h1)
    else $error("vc header type or version wrong");
  AST_NEXT_OFFSET_READ: assert property ( // RULE_09
    setup_phase & ~pwrite & hit_scap |=> prdata[31:20] == $past(serial_next_reg))
    else $error("next structure offset not shown");
  AST_UID_LOW_WRITE: assert property ( // RULE_10
    wr_fire & hit_uidl & ~lock_reg & ~soft_reset & (pstrb == 4'hf)
      |=> uid_low_reg == $past(pwdata) ##1 uid_low_reg == $past(uid_low_reg) || $past(soft_reset))
    else $error("unique id low write lost");
  AST_UID_HIGH_LOCKED: assert property ( // RULE_11
    wr_fire & hit_uidh & lock_reg & ~soft_reset |=> $stable(uid_high_reg))
    else $error("locked unique id high was written");

  // header log: last word capture, read-back of words 0 to 2, no change without a cause
  AST_LOG_WORD3_CAPTURE: assert property ( // RULE_04
    cap_take |=> log_reg[3] == $past(capture_header[127:96]))
    else $error("log word3 did not take header doubleword four");
  AST_LOG_WORD0_READ: assert property ( // RULE_01
    setup_phase & ~pwrite & hit_log0 |=> prdata == $past(log_reg[0]))
    else $error("log word0 read back wrong");
  AST_LOG_WORD1_READ: assert property ( // RULE_02
    setup_phase & ~pwrite & hit_log1 |=> prdata == $past(log_reg[1]))
    else $error("log word1 read back wrong");
  AST_LOG_WORD2_READ: assert property ( // RULE_03
    setup_phase & ~pwrite & hit_log2 |=> prdata == $past(log_reg[2]))
    else $error("log word2 read back wrong");
  AST_LOG_QUIET_WITHOUT_CAPTURE: assert property ( // RULE_05
    ~capture_valid & ~(wr_open & (|hit_log)) |=> $stable(log_reg[0]) && $stable(log_reg[1])
      && $stable(log_reg[2]) && $stable(log_reg[3]))
    else $error("header log changed with no capture and no write");
  AST_LOG_LOCKED_WRITE: assert property ( // RULE_05
    wr_fire & lock_reg & (|hit_log) & ~capture_valid |=> $stable(log_reg[0])
      && $stable(log_reg[1]) && $stable(log_reg[2]) && $stable(log_reg[3]))
    else $error("locked header log was written");

  // pointer keeps its value between accepted captures, status word shows it
  AST_POINTER_HOLD: assert property ( // RULE_06
    ~cap_take |=> $stable(ptr_reg))
    else $error("first error pointer moved without a capture");
  AST_POINTER_STATUS_READ: assert property ( // RULE_06
    setup_phase & ~pwrite & hit_ptr |=> prdata[4:0] == $past(ptr_reg)
      && prdata[8] == $past(ptr_valid))
    else $error("pointer status word read back wrong");

  // next offsets: read-back, both strobes needed, port reset restores them
  AST_VCHAN_NEXT_READ: assert property ( // RULE_09
    setup_phase & ~pwrite & hit_vcap |=> prdata[31:20] == $past(vchan_next_reg))
    else $error("vc next structure offset not shown");
  AST_NEXT_OFFSET_STROBES: assert property ( // RULE_09
    wr_fire & hit_scap & ~(pstrb[3] & pstrb[2]) & ~soft_reset |=> $stable(serial_next_reg))
    else $error("serial next offset written without both upper strobes");
  AST_NEXT_OFFSET_SOFT_RESET: assert property ( // RULE_09
    soft_reset |=> serial_next_reg == ehsvc_pkg::SERIAL_NEXT_RESET
      && vchan_next_reg == ehsvc_pkg::VCHAN_NEXT_RESET)
    else $error("next offsets not restored by port reset");

  // unique id words: lock, full write, port reset and read-back
  AST_UID_LOW_LOCKED: assert property ( // RULE_10
    wr_fire & hit_uidl & lock_reg & ~soft_reset |=> $stable(uid_low_reg))
    else $error("locked unique id low was written");
  AST_UID_HIGH_WRITE: assert property ( // RULE_11
    wr_fire & hit_uidh & ~lock_reg & ~soft_reset & (pstrb == 4'hf)
      |=> uid_high_reg == $past(pwdata))
    else $error("unique id high write lost");
  AST_UID_SOFT_RESET: assert property ( // RULE_10 RULE_11
    soft_reset |=> uid_low_reg == ehsvc_pkg::UNIQUE_ID_RESET
      && uid_high_reg == ehsvc_pkg::UNIQUE_ID_RESET)
    else $error("unique id not cleared by port reset");
  AST_UID_LOW_READ: assert property ( // RULE_10
    setup_phase & ~pwrite & hit_uidl |=> prdata == $past(uid_low_reg))
    else $error("unique id low read back wrong");
  AST_UID_HIGH_READ: assert property ( // RULE_11
    setup_phase & ~pwrite & hit_uidh |=> prdata == $past(uid_high_reg))
    else $error("unique id high read back wrong");
  AST_LOCK_SOFT_RESET: assert property (
    soft_reset |=> !lock_reg)
    else $error("write lock not cleared by port reset");

  // bus timing: no wait states, ready high in the first access cycle, error only for unmapped addresses
  AST_READY_AFTER_SETUP: assert property (
    setup_phase |=> pready)
    else $error("ready missing in access phase");
  AST_READY_ONE_CYCLE: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_UNMAPPED_ERROR: assert property (
    setup_phase & ~hit_any |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  AST_MAPPED_NO_ERROR: assert property (
    setup_phase & hit_any |=> !pslverr)
    else $error("mapped access flagged as error");
  AST_WRITE_READS_ZERO: assert property (
    setup_phase & pwrite |=> prdata == 32'h0000_0000)
    else $error("read data not zero on a write");

  COV_FIRST_ERROR: cover property (cap_take ##[1:20] rd_access & hit_log0);
  COV_SECOND_ERROR_BLOCKED: cover property (capture_valid & ptr_valid);
  COV_UNMAPPED: cover property (pslverr & pready);
  COV_LOCKED_WRITE: cover property (wr_fire & lock_reg & hit_uidl);
  COV_SOFT_RESET_KEEPS_LOG: cover property (soft_reset & (log_reg[0] != ehsvc_pkg::LOG_WORD_RESET));
endmodule // ehsvc_regs
`default_nettype wire

// File: test/test_error_header_serial_vc_caps.sv
// testbench for the error header log, unique id and structure header bank
`timescale 1ns/1ps
`default_nettype none
module test_error_header_serial_vc_caps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic soft_reset = 1'b0;
  logic capture_valid = 1'b0;
  logic [4:0] capture_bit = 5'h00;
  logic [127:0] capture_header = 128'h0;
  logic [31:0] error_status = 32'h0000_0000;
  logic [4:0] first_error_pointer;
  logic [63:0] unique_id;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int checked = 0;
  localparam logic [127:0] H1 = 128'h4444_0004_3333_0003_2222_0002_1111_0001;
  localparam logic [127:0] H2 = 128'hdddd_000d_cccc_000c_bbbb_000b_aaaa_000a;

  ehsvc_regs ehsvc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset),
    .capture_valid(capture_valid), .capture_bit(capture_bit),
    .capture_header(capture_header), .error_status(error_status),
    .first_error_pointer(first_error_pointer), .unique_id(unique_id));

  // 50 mhz bus clock
  always #10 pclk = ~pclk;

  task summarize;
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize;
    end
  endtask

  task rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, {31'h0, er, rd}, {32'h0, exp});
  endtask

  // all four log words against one expected header
  task logchk(input logic [127:0] h);
    for (int i = 0; i < 4; i++) begin
      rchk("log word", ehsvc_pkg::OFF_LOG_WORD0 + 12'(4 * i), h[32 * i +: 32]);
    end
  endtask

  // single-cycle error report from the detection logic
  task capture(input logic [4:0] b, input logic [127:0] h);
    @(posedge pclk);
    capture_valid <= 1'b1;
    capture_bit <= b;
    capture_header <= h;
    @(posedge pclk);
    capture_valid <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and constant header fields
    logchk(128'h0);
    rchk("serial hdr", ehsvc_pkg::OFF_SERIAL_CAP_HEADER, 32'h2001_0003);
    rchk("vc hdr", ehsvc_pkg::OFF_VCHAN_CAP_HEADER, 32'h0001_0002);
    rchk("id low", ehsvc_pkg::OFF_UNIQUE_ID_LOW, 32'h0);
    rchk("id high", ehsvc_pkg::OFF_UNIQUE_ID_HIGH, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    check("unmapped err", {63'h0, er}, 64'h1);
    // first error logged, later ones dropped while the pointed bit is set
    capture(5'd5, H1);
    @(posedge pclk);
    check("pointer", {59'h0, first_error_pointer}, 64'd5);
    logchk(H1);
    error_status <= 32'h0000_0020;
    capture(5'd7, H2);
    rchk("ptr status", ehsvc_pkg::OFF_ERROR_POINTER, 32'h0000_0105);
    logchk(H1);
    error_status <= 32'h0000_0000;
    capture(5'd7, H2);
    @(posedge pclk);
    check("pointer", {59'h0, first_error_pointer}, 64'd7);
    logchk(H2);
    // unique id halves, then locked against writes
    apb(1'b1, ehsvc_pkg::OFF_UNIQUE_ID_LOW, 32'h89ab_cdef);
    apb(1'b1, ehsvc_pkg::OFF_UNIQUE_ID_HIGH, 32'h0123_4567);
    rchk("id low", ehsvc_pkg::OFF_UNIQUE_ID_LOW, 32'h89ab_cdef);
    rchk("id high", ehsvc_pkg::OFF_UNIQUE_ID_HIGH, 32'h0123_4567);
    check("id port", unique_id, 64'h0123_4567_89ab_cdef);
    pstrb <= 4'h3;
    apb(1'b1, ehsvc_pkg::OFF_UNIQUE_ID_HIGH, 32'hffff_ffff);
    pstrb <= 4'hf;
    rchk("id high bytes", ehsvc_pkg::OFF_UNIQUE_ID_HIGH, 32'h0123_ffff);
    apb(1'b1, ehsvc_pkg::OFF_WRITE_LOCK, 32'h0000_0001);
    apb(1'b1, ehsvc_pkg::OFF_UNIQUE_ID_LOW, 32'h5555_5555);
    apb(1'b1, ehsvc_pkg::OFF_LOG_WORD2, 32'h1234_5678);
    rchk("locked id", ehsvc_pkg::OFF_UNIQUE_ID_LOW, 32'h89ab_cdef);
    apb(1'b1, ehsvc_pkg::OFF_WRITE_LOCK, 32'h0000_0000);
    apb(1'b1, ehsvc_pkg::OFF_LOG_WORD1, 32'h5a5a_5a5a);
    // next offsets writable, type and version fields stay fixed
    apb(1'b1, ehsvc_pkg::OFF_SERIAL_CAP_HEADER, 32'h0000_ffff);
    rchk("serial hdr", ehsvc_pkg::OFF_SERIAL_CAP_HEADER, 32'h0001_0003);
    apb(1'b1, ehsvc_pkg::OFF_VCHAN_CAP_HEADER, 32'h1800_ffff);
    rchk("vc hdr", ehsvc_pkg::OFF_VCHAN_CAP_HEADER, 32'h1801_0002);
    // port reset clears the id but keeps the sticky log
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rchk("id low", ehsvc_pkg::OFF_UNIQUE_ID_LOW, 32'h0);
    rchk("serial hdr", ehsvc_pkg::OFF_SERIAL_CAP_HEADER, 32'h2001_0003);
    logchk({H2[127:64], 32'h5a5a_5a5a, H2[31:0]});
    check("pointer", {59'h0, first_error_pointer}, 64'd7);
    // power-on reset in mid-run clears the sticky log and pointer as well
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    logchk(128'h0);
    check("pointer", {59'h0, first_error_pointer}, 64'd0);
    summarize;
  end
endmodule // test_error_header_serial_vc_caps
`default_nettype wire
